//--- rtl/chan_ida_pkg.sv
// constants and types for the channel indirect data addressing engine
package chan_ida_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_LIST_PTR = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_CUR_ADDR = 8'h14;
  localparam logic [7:0] OFS_CCW_PTR  = 8'h18;
  localparam int         CTRL_START_POS = 0;
  localparam int         IRQ_W          = 2;
  localparam int         IRQ_DONE_POS   = 0;
  localparam int         IRQ_PCHK_POS   = 1;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_DECERR    = 2'h3;
  // ==========================================================
  // command word layout
  localparam int         ADDR_W       = 24;
  localparam int         FLAG_CD_POS  = 31;
  localparam int         FLAG_CC_POS  = 30;
  localparam int         FLAG_IDA_POS = 26;
  localparam int         BLOCK_BITS   = 11;
  localparam logic [3:0] CMD_RBWD     = 4'hC;
  localparam logic [23:0] CCW_STEP    = 24'h000008;
  localparam logic [23:0] WORD_STEP   = 24'h000004;
  localparam logic [23:0] ONE_STEP    = 24'h000001;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CCW0 = 3'b001,
    S_CCW1 = 3'b010,
    S_INDIRECT_ADDR_WORD = 3'b011,
    S_XA   = 3'b100,
    S_XB   = 3'b101
  } state_type;
  typedef struct packed {
    logic [23:0] addr;
    logic        write;
    logic        word;
    logic [31:0] wdata;
  } mem_req_type;
endpackage

//--- rtl/channel_indirect_data_addressing.sv
// channel engine that walks command words and indirect address lists
// Function
// - bit 37 of each command word is the indirect addressing flag
// - flag honoured for every data command, in either control mode
// - flag clear: command address field is the data start address
// - flag set: command address field locates the address list
// - first list word may hold any real address
// - later list words must start a block (end one when backward), else program check
// - start fetches first command word at list pointer, checks bit 37
// - flag set: fetch first list word, then transfer at its address
// - forward transfers step upward until a 2048-byte boundary
// - low eleven bits rolling to zero fetches the next list word
// - list words are fetched only when their block is reached
// - list used until count ends, then chain to next command word
`timescale 1ns/1ps
`default_nettype none
module channel_indirect_data_addressing
  import chan_ida_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // axi4-lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // processor storage
  output logic             mem_valid_o,
  output var mem_req_type  mem_req_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  // device byte stream
  output logic             dev_out_valid_o,
  output logic [7:0]       dev_out_data_o,
  input  wire logic        dev_out_ready_i,
  input  wire logic        dev_in_valid_i,
  input  wire logic [7:0]  dev_in_data_i,
  output logic             dev_in_ready_o,
  // interrupt
  output logic             irq_o
);
  // ==========================================================
  // state
  state_type        state;
  logic [23:0]      ccw_ptr;
  logic [23:0]      list_ptr;
  logic [23:0]      cur_addr;
  logic [23:0]      indirect_addr_list_ptr;
  logic [7:0]       cmd;
  logic [31:0]      flags;
  logic [15:0]      count;
  logic             first_indirect_addr_word;
  logic             data_chain;
  logic [7:0]       byte_buf;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic             aw_held;
  logic             w_held;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             wr_fire;
  logic             start;
  logic             ida;
  logic             bwd;
  logic             outbound;
  logic             byte_done;
  logic             last_byte;
  logic             crossing;
  logic             indirect_addr_word_bad;
  logic [23:0]      next_addr;
  logic             ccw_end;
  logic             chain;
  logic             chain_data;
  logic [IRQ_W-1:0] ev;

  assign ida      = flags[FLAG_IDA_POS];
  // no mode gating: the flag acts the same for every command code
  assign bwd      = (cmd[3:0] == CMD_RBWD);
  assign outbound = cmd[0];
  // a zero count ends the command in the very cycle its flags arrive
  assign chain_data = (state == S_CCW1) ? mem_rdata_i[FLAG_CD_POS] : flags[FLAG_CD_POS];
  assign chain      = chain_data
                    | ((state == S_CCW1) ? mem_rdata_i[FLAG_CC_POS] : flags[FLAG_CC_POS]);
  assign byte_done = outbound ? (state == S_XB && dev_out_ready_i)
                              : (state == S_XB && mem_ack_i);
  assign last_byte = (count == 16'h0001);
  assign next_addr = bwd ? cur_addr - ONE_STEP : cur_addr + ONE_STEP;
  // boundary: forward rolls to all zeros, backward leaves a block start
  assign crossing  = ida && (bwd ? (cur_addr[BLOCK_BITS-1:0] == '0)
                                 : (next_addr[BLOCK_BITS-1:0] == '0));
  assign indirect_addr_word_bad  = !first_indirect_addr_word && ((mem_rdata_i[31:24] != 8'h00)
                   || (bwd ? (mem_rdata_i[BLOCK_BITS-1:0] != '1)
                           : (mem_rdata_i[BLOCK_BITS-1:0] != '0)));
  assign ccw_end   = (byte_done && last_byte)
                   || (state == S_CCW1 && mem_ack_i && mem_rdata_i[15:0] == 16'h0000);

  // ==========================================================
  // storage requests
  always_comb
  begin
    mem_valid_o     = 1'b0;
    mem_req_o       = '0;
    mem_req_o.word  = 1'b1;
    mem_req_o.addr  = ccw_ptr;
    unique case (state)
      S_IDLE: mem_valid_o = 1'b0;
      S_CCW0: mem_valid_o = 1'b1;
      S_CCW1:
      begin
        mem_valid_o    = 1'b1;
        mem_req_o.addr = ccw_ptr + WORD_STEP;
      end
      S_INDIRECT_ADDR_WORD:
      begin
        mem_valid_o    = 1'b1;
        mem_req_o.addr = indirect_addr_list_ptr;
      end
      S_XA:
      begin
        mem_valid_o    = outbound;
        mem_req_o.word = 1'b0;
        mem_req_o.addr = cur_addr;
      end
      S_XB:
      begin
        mem_valid_o     = !outbound;
        mem_req_o.word  = 1'b0;
        mem_req_o.write = 1'b1;
        mem_req_o.addr  = cur_addr;
        mem_req_o.wdata = {24'h000000, byte_buf};
      end
    endcase
  end

  assign dev_out_valid_o = (state == S_XB) && outbound;
  assign dev_out_data_o  = byte_buf;
  assign dev_in_ready_o  = (state == S_XA) && !outbound;

  // ==========================================================
  // channel sequencer
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state      <= S_IDLE;
      ccw_ptr    <= '0;
      cur_addr   <= '0;
      indirect_addr_list_ptr   <= '0;
      cmd        <= '0;
      flags      <= '0;
      count      <= '0;
      first_indirect_addr_word <= 1'b0;
      data_chain <= 1'b0;
      byte_buf   <= '0;
    end
    else
    begin
      unique case (state)
        S_IDLE:
          if (start)
          begin
            ccw_ptr    <= list_ptr;
            data_chain <= 1'b0;
            state      <= S_CCW0;
          end
        S_CCW0:
          if (mem_ack_i)
          begin
            if (!data_chain)
              cmd <= mem_rdata_i[31:24];
            cur_addr <= mem_rdata_i[23:0];
            indirect_addr_list_ptr <= mem_rdata_i[23:0];
            state    <= S_CCW1;
          end
        S_CCW1:
          if (mem_ack_i)
          begin
            flags      <= mem_rdata_i;
            count      <= mem_rdata_i[15:0];
            first_indirect_addr_word <= 1'b1;
            if (mem_rdata_i[15:0] == 16'h0000)
              state <= S_IDLE;
            else if (mem_rdata_i[FLAG_IDA_POS])
              state <= S_INDIRECT_ADDR_WORD;
            else
              state <= S_XA;
          end
        S_INDIRECT_ADDR_WORD:
          if (mem_ack_i)
          begin
            if (indirect_addr_word_bad)
              state <= S_IDLE;
            else
            begin
              cur_addr   <= mem_rdata_i[23:0];
              indirect_addr_list_ptr   <= indirect_addr_list_ptr + WORD_STEP;
              first_indirect_addr_word <= 1'b0;
              state      <= S_XA;
            end
          end
        S_XA:
          if (outbound && mem_ack_i)
          begin
            byte_buf <= mem_rdata_i[7:0];
            state    <= S_XB;
          end
          else if (!outbound && dev_in_valid_i)
          begin
            byte_buf <= dev_in_data_i;
            state    <= S_XB;
          end
        S_XB:
          if (byte_done)
          begin
            count    <= count - 16'h0001;
            cur_addr <= next_addr;
            if (last_byte)
              state <= S_IDLE;
            else if (crossing)
              state <= S_INDIRECT_ADDR_WORD;
            else
              state <= S_XA;
          end
      endcase
      if (ccw_end && chain)
      begin
        ccw_ptr    <= ccw_ptr + CCW_STEP;
        data_chain <= chain_data;
        state      <= S_CCW0;
      end
    end
  end

  // ==========================================================
  // interrupt status, mask and software registers
  always_comb
  begin
    ev               = '0;
    ev[IRQ_DONE_POS] = ccw_end && !chain;
    ev[IRQ_PCHK_POS] = (state == S_INDIRECT_ADDR_WORD) && mem_ack_i && indirect_addr_word_bad;
  end

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign start   = wr_fire && (aw_addr == OFS_CTRL) && w_data[CTRL_START_POS]
                && w_strb[0] && (state == S_IDLE);

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_stat <= '0;
      irq_mask <= '0;
      list_ptr <= '0;
    end
    else
    begin
      // a new event in the clearing cycle survives the clear
      if (wr_fire && aw_addr == OFS_IRQ_STAT && w_strb[0])
        irq_stat <= (irq_stat & ~w_data[IRQ_W-1:0]) | ev;
      else
        irq_stat <= irq_stat | ev;
      if (wr_fire && aw_addr == OFS_IRQ_MASK && w_strb[0])
        irq_mask <= w_data[IRQ_W-1:0];
      if (wr_fire && aw_addr == OFS_LIST_PTR)
      begin
        if (w_strb[0]) list_ptr[7:0]   <= w_data[7:0];
        if (w_strb[1]) list_ptr[15:8]  <= w_data[15:8];
        if (w_strb[2]) list_ptr[23:16] <= w_data[23:16];
      end
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // ==========================================================
  // axi4-lite write and read channels
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == OFS_CTRL || aw_addr == OFS_LIST_PTR
                      || aw_addr == OFS_IRQ_STAT || aw_addr == OFS_IRQ_MASK)
                      ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        OFS_CTRL:     s_axi_rdata <= '0;
        OFS_LIST_PTR: s_axi_rdata <= {8'h00, list_ptr};
        OFS_STATUS:   s_axi_rdata <= {28'h0000000, (state != S_IDLE), state};
        OFS_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat};
        OFS_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask};
        OFS_CUR_ADDR: s_axi_rdata <= {8'h00, cur_addr};
        OFS_CCW_PTR:  s_axi_rdata <= {8'h00, ccw_ptr};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // assertions
  AST_START_FETCH: assert property (@(posedge clock_i) disable iff (rst_i)
    start |=> state == S_CCW0 && mem_valid_o && mem_req_o.addr == $past(list_ptr))
    else $error("start did not fetch the first command word");
  AST_IDA_LIST: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == S_CCW1 && mem_ack_i && mem_rdata_i[FLAG_IDA_POS] && mem_rdata_i[15:0] != 0)
    |=> state == S_INDIRECT_ADDR_WORD && mem_req_o.addr == cur_addr)
    else $error("flag set but no list word fetched");
  AST_DIRECT: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == S_CCW1 && mem_ack_i && !mem_rdata_i[FLAG_IDA_POS] && mem_rdata_i[15:0] != 0)
    |=> state == S_XA && $stable(cur_addr))
    else $error("direct transfer did not start at command address");
  AST_ASCEND: assert property (@(posedge clock_i) disable iff (rst_i)
    (byte_done && !bwd) |=> cur_addr == $past(cur_addr) + ONE_STEP)
    else $error("forward address did not step up");
  AST_DESCEND: assert property (@(posedge clock_i) disable iff (rst_i)
    (byte_done && bwd) |=> cur_addr == $past(cur_addr) - ONE_STEP)
    else $error("backward address did not step down");
  AST_CROSS: assert property (@(posedge clock_i) disable iff (rst_i)
    (byte_done && !last_byte && ida && !bwd && cur_addr[BLOCK_BITS-1:0] == '1)
    |=> state == S_INDIRECT_ADDR_WORD ##1 state == S_INDIRECT_ADDR_WORD || state == S_XA || state == S_IDLE)
    else $error("block crossing did not fetch next list word");
  AST_NO_PREFETCH: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == S_INDIRECT_ADDR_WORD && $past(state) == S_XB) |-> $past(!last_byte && crossing))
    else $error("list word fetched before its block");
  AST_PCHECK: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == S_INDIRECT_ADDR_WORD && mem_ack_i && !first_indirect_addr_word
     && mem_rdata_i[BLOCK_BITS-1:0] != {BLOCK_BITS{bwd}})
    |=> irq_stat[IRQ_PCHK_POS] && state == S_IDLE)
    else $error("misaligned list word not checked");
  AST_FIRST_ANY: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == S_INDIRECT_ADDR_WORD && mem_ack_i && first_indirect_addr_word && mem_rdata_i[31:24] == 0)
    |=> state == S_XA && cur_addr == $past(mem_rdata_i[23:0]))
    else $error("first list word was refused");
  AST_CHAIN: assert property (@(posedge clock_i) disable iff (rst_i)
    (byte_done && last_byte && chain) |=> state == S_CCW0
    && ccw_ptr == $past(ccw_ptr) + CCW_STEP)
    else $error("chaining did not fetch the next command word");
endmodule // channel_indirect_data_addressing
`default_nettype wire

//--- bench/store_model.sv
// processor storage model answering word fetches and byte accesses
`timescale 1ns/1ps
`default_nettype none
module store_model
  import chan_ida_pkg::*;
(
  // clock, reset and pacing
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  // storage requests
  input  wire logic        mem_valid_i,
  input  wire mem_req_type mem_req_i,
  output logic             mem_ack_o,
  output logic [31:0]      mem_rdata_o
);
  logic [7:0]  mem [0:16383];
  logic [23:0] fetch_log [$];
  logic        seen;
  logic [31:0] rnd;
  logic [13:0] a;
  mem_req_type req;
  // ==========================================================
  // request sampled mid-cycle so it never races the engine's edge
  always @(negedge clock_i)
  begin
    seen = mem_valid_i;
    req  = mem_req_i;
  end
  // idle data lines toggle every cycle, so stale data is never mistaken
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= 32'h5A5AA5A5;
      rnd = 32'h0000ACE1;
    end
    else
    begin
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      a = req.addr[13:0];
      mem_rdata_o <= ~mem_rdata_o;
      mem_ack_o   <= 1'b0;
      if (mem_ack_o)
      begin
        if (req.write)
          mem[a] <= req.wdata[7:0];
        if (req.word)
          fetch_log.push_back(req.addr);
      end
      else if (seen && (!slow_i || rnd[1:0] == 2'h0))
      begin
        mem_ack_o   <= 1'b1;
        mem_rdata_o <= req.word ? {mem[a], mem[a + 14'h1], mem[a + 14'h2], mem[a + 14'h3]}
                                : {~mem_rdata_o[31:8], mem[a]};
      end
    end
  end
endmodule // store_model
`default_nettype wire

//--- bench/channel_indirect_data_addressing_tb_top.sv
// self-checking bench for the channel indirect data addressing engine
`timescale 1ns/1ps
`default_nettype none
module channel_indirect_data_addressing_tb_top;
  import chan_ida_pkg::*;
  // ==========================================================
  // signals
  logic        clock_i = 1'b0, rst_i = 1'b1, slow = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        ivalid = 1'b0, oready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, idata = 8'h00;
  logic [31:0] wdata = 32'h0, seed = 32'h0000ADA5, v;
  logic        awready, wready, bvalid, arready, rvalid, irq, mvalid, mack;
  logic        ovalid, iready, tin, tout;
  logic [1:0]  bresp, rresp;
  logic [7:0]  odata;
  logic [31:0] rdata, mrdata;
  mem_req_type mreq;
  logic [7:0]  xout [$], got_out [$], got_in [$];
  logic [23:0] xaddr [$], xfetch [$];
  logic [7:0]  cmds [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h0C};
  int          miscompares = 0;
  int          cmp_count = 0;

  channel_indirect_data_addressing channel_indirect_data_addressing_i (
    .clock_i(clock_i), .rst_i(rst_i),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .mem_valid_o(mvalid), .mem_req_o(mreq), .mem_ack_i(mack), .mem_rdata_i(mrdata),
    .dev_out_valid_o(ovalid), .dev_out_data_o(odata), .dev_out_ready_i(oready),
    .dev_in_valid_i(ivalid), .dev_in_data_i(idata), .dev_in_ready_o(iready), .irq_o(irq));
  store_model store (.clock_i(clock_i), .rst_i(rst_i), .slow_i(slow),
    .mem_valid_i(mvalid), .mem_req_i(mreq), .mem_ack_o(mack), .mem_rdata_o(mrdata));

  always #25 clock_i = ~clock_i;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // ==========================================================
  // checking and closing
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("wrong value at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
      finish_test();
    end
  endtask
  // ==========================================================
  // device end offers and accepts bytes at random, stalling the engine
  always @(negedge clock_i)
  begin
    tin  = ivalid & iready;
    tout = ovalid & oready;
    if (tout)
      got_out.push_back(odata);
  end
  always @(posedge clock_i)
  begin
    v = rnd();
    if (tin)
      got_in.push_back(idata);
    if (tin || !ivalid)
      ivalid <= v[3];
    if (tin || !ivalid)
      idata <= v[15:8];
    oready <= v[9];
  end
  // ==========================================================
  // register bus master; the extra edge keeps strobes from toggling twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic at, wt, bt;
    logic [1:0] r;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clock_i);
      at = awvalid & awready;
      wt = wvalid & wready;
      bt = bvalid;
      r  = bresp;
      @(posedge clock_i);
      if (at)
        awvalid <= 1'b0;
      if (wt)
        wvalid <= 1'b0;
      n++;
    end
    while (!bt && n < 200);
    bready <= 1'b0;
    @(posedge clock_i);
    tmo(bt);
    cmp({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic at, t;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clock_i);
      at = arvalid & arready;
      t  = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clock_i);
      if (at)
        arvalid <= 1'b0;
      n++;
    end
    while (!t && n < 200);
    rready <= 1'b0;
    @(posedge clock_i);
    tmo(t);
  endtask
  // ==========================================================
  // command list building and expected traffic
  task automatic put32(input logic [13:0] a, input logic [31:0] d);
    for (int b = 0; b < 4; b++)
      store.mem[a + 14'(b)] = d[31 - 8 * b -: 8];
  endtask
  task automatic plan(input int k, input logic [7:0] cmd, input logic indirect,
                      input logic cc, input logic bad);
    logic [23:0] a;
    logic [23:0] w [2];
    logic [13:0] c, l;
    logic        bwd;
    int          d, n, i, j;
    bwd = (cmd[3:0] == CMD_RBWD);
    c   = 14'(16'h0100 + 8 * k);
    l   = 14'(16'h0200 + 16 * k);
    d   = int'(1 + rnd() % 16);
    for (j = 0; j < 2; j++)
      w[j] = 24'((2 + 3 * k + (j + 2) % 3) * 2048 + (bwd ? 2047 : 0));
    if (indirect)
      w[0] = bwd ? w[0] - 24'h7FF + 24'(d - 1) : w[0] + 24'(2048 - d);
    else
      w[0] = w[0] ^ 24'h400 ^ 24'(d * 4);
    if (bad)
      w[1] = w[1] ^ 24'h4;
    n = indirect ? d + 1 + int'(rnd() % 24) : 1 + int'(rnd() % 48);
    put32(c, {cmd, indirect ? {10'h0, l} : w[0]});
    put32(c + 14'h4, (32'(cc) << FLAG_CC_POS) | (32'(indirect) << FLAG_IDA_POS)
          | 32'(n));
    for (j = 0; j < 2; j++)
      put32(l + 14'(4 * j), {8'h00, w[j]});
    xfetch.push_back({10'h0, c});
    xfetch.push_back({10'h0, c + 14'h4});
    if (indirect)
      xfetch.push_back({10'h0, l});
    a = w[0];
    j = 0;
    for (i = 0; i < n; i++)
    begin
      if (cmd[0])
        xout.push_back(store.mem[a[13:0]]);
      else
        xaddr.push_back(a);
      if (indirect && i < n - 1 && a[10:0] == (bwd ? 11'h000 : 11'h7FF))
      begin
        j++;
        a = w[j];
        xfetch.push_back({10'h0, l + 14'(4 * j)});
      end
      else
        a = bwd ? a - 24'h1 : a + 24'h1;
    end
  endtask
  task automatic run(input logic [1:0] em, input logic [1:0] ev);
    logic [31:0] d, mk, u;
    logic [1:0]  r;
    int          n;
    store.fetch_log.delete();
    got_out.delete();
    got_in.delete();
    u    = rnd();
    mk   = (em == 2'h2) ? 32'h2 : u & 32'h3;
    slow <= u[2];
    wr(OFS_IRQ_MASK, mk, RESP_OKAY);
    wr(OFS_LIST_PTR, 32'h00000100, RESP_OKAY);
    wr(OFS_CTRL, 32'h00000001, RESP_OKAY);
    n = 0;
    do
    begin
      rd(OFS_STATUS, d, r);
      n++;
    end
    while (d[3] !== 1'b0 && n < 500);
    tmo(d[3] === 1'b0);
    rd(OFS_IRQ_STAT, d, r);
    cmp(d & {30'h0, em}, {30'h0, ev});
    cmp({31'h0, irq}, {31'h0, |(mk[1:0] & ev)});
    wr(OFS_IRQ_STAT, 32'h3, RESP_OKAY);
    cmp({31'h0, irq}, 32'h0);
    if (em == 2'h3)
    begin
      cmp(32'(got_out.size()), 32'(xout.size()));
      foreach (xout[q]) cmp({24'h0, got_out[q]}, {24'h0, xout[q]});
      cmp(32'(got_in.size()), 32'(xaddr.size()));
      foreach (xaddr[q]) cmp({24'h0, store.mem[xaddr[q][13:0]]}, {24'h0, got_in[q]});
    end
    cmp(32'(store.fetch_log.size()), 32'(xfetch.size()));
    foreach (xfetch[q]) cmp({8'h0, store.fetch_log[q]}, {8'h0, xfetch[q]});
    xout.delete();
    xaddr.delete();
    xfetch.delete();
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    int          c;
    for (c = 0; c < 16384; c++)
      store.mem[c] = 8'(rnd());
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    rd(OFS_STATUS, d, r);
    cmp(d, 32'h0);
    rd(OFS_IRQ_STAT, d, r);
    cmp(d, 32'h0);
    rd(8'h1C, d, r);
    cmp({30'h0, r}, {30'h0, RESP_DECERR});
    wr(OFS_CUR_ADDR, 32'h0, RESP_DECERR);
    wr(8'h40, 32'h0, RESP_DECERR);
    for (c = 0; c < 30; c++)
    begin
      plan(0, cmds[c % 5], 1'(c / 5), 1'b0, 1'b0);
      run(2'h3, 2'h1);
    end
    plan(0, 8'h01, 1'b0, 1'b1, 1'b0);
    plan(1, 8'h0C, 1'b1, 1'b0, 1'b0);
    run(2'h3, 2'h1);
    plan(0, 8'h02, 1'b1, 1'b1, 1'b0);
    plan(1, 8'h03, 1'b1, 1'b0, 1'b0);
    run(2'h3, 2'h1);
    // data chaining: the chained word's command byte must be ignored
    plan(0, 8'h01, 1'b0, 1'b1, 1'b0);
    store.mem[14'h104] = 8'hC0;
    plan(1, 8'h01, 1'b1, 1'b0, 1'b0);
    store.mem[14'h108] = 8'h02;
    run(2'h3, 2'h1);
    plan(0, 8'h02, 1'b1, 1'b0, 1'b1);
    run(2'h2, 2'h2);
    plan(0, 8'h0C, 1'b1, 1'b0, 1'b1);
    run(2'h2, 2'h2);
    finish_test();
  end
endmodule // channel_indirect_data_addressing_tb_top
`default_nettype wire
